// >>> rtl/wdtr_pkg.sv
/*
 * constants, register map and state codes of the watchdog restart unit.
 * assumes one 100 MHz core clock that is also the oscillator clock.
 */
// Contract
// - watchdog off after any reset
// - arm by writing 1E then E1, back to back
// - armed counter advances once per machine cycle
// - once armed, nothing but reset stops it
// - overflow drives a chip reset pulse
// - reset pulse lasts 96 oscillator periods
// - period writes ignored while armed
// - 14-bit stage then 7-bit programmable stage
// - period select in bits 2 to 0
// - overflow after 2^(14+S)-1 machine cycles
// - power-down freezes counter, no overflow; here the chain is cleared and held at zero
// - hardware reset exit leaves watchdog disabled
// - after interrupt wake, count only once high
// - idle keeps counting; software restarts periodically
package wdtr_pkg;
	// ----------------------------------------
	// register map, byte addresses
	// ----------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [7:0] IDX_RESTART = 8'hA6; // restart register index
	localparam logic [7:0] IDX_PERIOD = 8'hA7; // period register index
	localparam logic [7:0] IDX_MODE = 8'hA8; // power mode register index
	localparam logic [7:0] IDX_STATUS = 8'hA9; // status register index
	localparam logic [7:0] IDX_COUNT = 8'hAA; // counter readback index
	localparam logic [ADDR_W-1:0] A_RESTART = {2'h0, IDX_RESTART, 2'h0};
	localparam logic [ADDR_W-1:0] A_PERIOD = {2'h0, IDX_PERIOD, 2'h0};
	localparam logic [ADDR_W-1:0] A_MODE = {2'h0, IDX_MODE, 2'h0};
	localparam logic [ADDR_W-1:0] A_STATUS = {2'h0, IDX_STATUS, 2'h0};
	localparam logic [ADDR_W-1:0] A_COUNT = {2'h0, IDX_COUNT, 2'h0};

	// ----------------------------------------
	// unlock bytes and field layout
	// ----------------------------------------
	localparam logic [7:0] KEY_FIRST = 8'h1E; // first unlock byte
	localparam logic [7:0] KEY_SECOND = 8'hE1; // second unlock byte
	localparam int SEL_W = 3; // period select width
	localparam logic [SEL_W-1:0] SEL_RST = 3'h0; // period select reset
	localparam int MODE_PD_BIT = 0; // power-down request bit
	localparam int MODE_IDLE_BIT = 1; // idle request bit
	localparam int ST_ARMED_BIT = 0; // status: armed
	localparam int ST_FIRE_BIT = 1; // status: reset pulse active
	localparam int ST_HOLD_BIT = 2; // status: wake hold

	// ----------------------------------------
	// counter chain and timing
	// ----------------------------------------
	localparam int PRE_W = 14; // first stage width
	localparam int PRG_W = 7; // programmable stage width
	localparam int CNT_W = PRE_W + PRG_W; // full chain width
	localparam int MC_W = 4; // machine cycle divider width
	localparam logic [MC_W-1:0] MC_LAST = 4'hB; // 12 oscillator periods
	localparam int CLK_PERIOD_PS = 10000; // core clock period
	localparam int OSC_PERIOD_PS = 10000; // oscillator period, same clock
	localparam int PULSE_OSC = 96; // reset pulse length, oscillator periods
	localparam int PULSE_PS = PULSE_OSC * OSC_PERIOD_PS;
	localparam int PULSE_CYC = PULSE_PS / CLK_PERIOD_PS;
	localparam int PW = 7; // pulse counter width
	localparam logic [PW-1:0] PULSE_LAST = PW'(PULSE_CYC - 1);

	// watchdog state, one-hot
	typedef enum logic [2:0] {
		WD_OFF = 3'h1,
		WD_ON = 3'h2,
		WD_FIRE = 3'h4
	} wdtr_state_t;
endpackage : wdtr_pkg

// >>> rtl/wdtr_cnt_if.sv
/*
 * link between the watchdog control and its counter chain.
 * assumes both ends share the core clock.
 */
`timescale 1ns/1ps
interface wdtr_cnt_if;
	logic run; // count enable
	logic clear; // clear both stages
	logic [wdtr_pkg::SEL_W-1:0] sel; // period select in use
	logic ovf; // overflow level
	logic [wdtr_pkg::CNT_W-1:0] count; // full chain value
	modport ctl (output run, output clear, output sel, input ovf, input count);
	modport cnt (input run, input clear, input sel, output ovf, output count);
endinterface : wdtr_cnt_if

// >>> rtl/wdtr_counter.sv
/*
 * machine cycle divider plus 14-bit and 7-bit counter stages.
 * assumes the control end holds clear for one cycle to restart.
 */
`timescale 1ns/1ps
module wdtr_counter (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic NRST,
	// control link
	wdtr_cnt_if.cnt lnk
);
	logic [wdtr_pkg::MC_W-1:0] mc_reg, mc_next; // oscillator periods in cycle
	logic [wdtr_pkg::PRE_W-1:0] pre_reg, pre_next; // first stage
	logic [wdtr_pkg::PRG_W-1:0] prg_reg, prg_next; // programmable stage
	logic [wdtr_pkg::CNT_W-1:0] limit; // terminal count for select
	logic tick; // machine cycle end

	// ------------------------------------------------
	// next state of divider and stages
	// ------------------------------------------------
	always_comb begin
		tick = (mc_reg == wdtr_pkg::MC_LAST);
		mc_next = mc_reg;
		pre_next = pre_reg;
		prg_next = prg_reg;
		// terminal count is 2^(14+S)-1
		limit = (wdtr_pkg::CNT_W'(1) << (5'(wdtr_pkg::PRE_W) + {2'h0, lnk.sel}))
			- wdtr_pkg::CNT_W'(1);
		if (lnk.clear || !lnk.run) begin
			// stopped chain restarts from zero and a fresh machine cycle
			mc_next = '0;
			pre_next = '0;
			prg_next = '0;
		end else if (tick) begin
			mc_next = '0;
			// carry from the first stage feeds the programmable one
			{prg_next, pre_next} = {prg_reg, pre_reg} + wdtr_pkg::CNT_W'(1);
		end else begin
			mc_next = mc_reg + wdtr_pkg::MC_W'(1);
		end
	end

	// registers only
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			mc_reg <= '0;
			pre_reg <= '0;
			prg_reg <= '0;
		end else begin
			mc_reg <= mc_next;
			pre_reg <= pre_next;
			prg_reg <= prg_next;
		end
	end

	assign lnk.count = {prg_reg, pre_reg};
	assign lnk.ovf = lnk.run && ({prg_reg, pre_reg} == limit);

	// ------------------------------------------------
	// checks
	// ------------------------------------------------
	frozen_when_stopped_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		!lnk.run |=> (lnk.count == '0))
		else $error("counter moved while stopped");
	one_step_per_mc_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(lnk.run && !lnk.clear && !tick) |=> $stable(lnk.count))
		else $error("counter stepped inside a machine cycle");
	clear_zeroes_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		lnk.clear |=> (lnk.count == '0) && (mc_reg == '0))
		else $error("restart did not clear chain");
endmodule : wdtr_counter

// >>> rtl/wdtr_top.sv
/*
 * watchdog restart unit: ahb-lite register slave, unlock sequence,
 * arming state, power-down hold of the chain at zero and the chip reset pulse.
 * assumes a single ahb-lite master, word transfers, synchronous inputs.
 */
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
module wdtr_top (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic NRST,
	// ahb-lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// wake interrupt pin and chip reset pin
	input wire logic WAKE_INT_N,
	output logic CHIP_RST_OUT
);
	wdtr_cnt_if lnk ();

	// bus pipeline
	logic dp_reg, dp_next; // data phase pending
	logic dp_wr_reg, dp_wr_next; // pending phase is a write
	logic [wdtr_pkg::ADDR_W-1:0] dp_addr_reg, dp_addr_next; // pending address
	logic [31:0] rdata_reg, rdata_next; // read data for data phase
	logic aphase; // address phase taken
	// software state
	logic seq_reg, seq_next; // first key byte just written
	logic [wdtr_pkg::SEL_W-1:0] period_reg, period_next; // stored select
	logic [wdtr_pkg::SEL_W-1:0] act_sel_reg, act_sel_next; // select in use
	logic pd_reg, pd_next; // power-down, oscillator halted
	logic idle_reg, idle_next; // idle, oscillator runs
	logic hold_reg, hold_next; // woken, waiting for pin high
	logic clr_reg, clr_next; // restart request to chain
	// watchdog state and pulse
	wdtr_pkg::wdtr_state_t st_reg, st_next;
	logic [wdtr_pkg::PW-1:0] pcnt_reg, pcnt_next; // pulse length count
	logic rst_out_reg, rst_out_next; // reset pin drive
	logic key_done; // second key byte completes sequence
	logic wr_dp; // write data phase now

	// ------------------------------------------------
	// address decode and bus next state
	// ------------------------------------------------
	always_comb begin
		aphase = HSEL && HTRANS[1] && HREADY;
		dp_next = aphase;
		dp_wr_next = aphase && HWRITE;
		dp_addr_next = HADDR[wdtr_pkg::ADDR_W-1:0];
		rdata_next = '0;
		// reads sampled at the address edge; unmapped reads give zero
		if (aphase && !HWRITE) begin
			unique case (HADDR[wdtr_pkg::ADDR_W-1:0])
				wdtr_pkg::A_PERIOD: rdata_next = {29'h0, period_reg};
				wdtr_pkg::A_MODE: rdata_next = {30'h0, idle_reg, pd_reg};
				wdtr_pkg::A_STATUS: rdata_next = {29'h0, hold_reg,
					(st_reg == wdtr_pkg::WD_FIRE), (st_reg == wdtr_pkg::WD_ON)};
				wdtr_pkg::A_COUNT: rdata_next = {11'h0, lnk.count};
				default: rdata_next = '0;
			endcase
		end
	end

	// ------------------------------------------------
	// software registers, unlock sequence, power modes
	// ------------------------------------------------
	always_comb begin
		wr_dp = dp_reg && dp_wr_reg;
		key_done = wr_dp && seq_reg && (dp_addr_reg == wdtr_pkg::A_RESTART)
			&& (HWDATA[7:0] == wdtr_pkg::KEY_SECOND);
		// any completed transfer other than the first key breaks the pair
		seq_next = dp_reg ? (wr_dp && (dp_addr_reg == wdtr_pkg::A_RESTART)
			&& (HWDATA[7:0] == wdtr_pkg::KEY_FIRST)) : seq_reg;
		period_next = period_reg;
		act_sel_next = act_sel_reg;
		pd_next = pd_reg;
		idle_next = idle_reg;
		hold_next = hold_reg;
		clr_next = key_done;
		// select is locked out while the watchdog is armed
		if (wr_dp && (dp_addr_reg == wdtr_pkg::A_PERIOD) && (st_reg == wdtr_pkg::WD_OFF)) begin
			period_next = HWDATA[wdtr_pkg::SEL_W-1:0];
		end
		if (key_done && (st_reg == wdtr_pkg::WD_OFF)) begin
			act_sel_next = period_reg;
		end
		if (wr_dp && (dp_addr_reg == wdtr_pkg::A_MODE)) begin
			pd_next = HWDATA[wdtr_pkg::MODE_PD_BIT];
			idle_next = HWDATA[wdtr_pkg::MODE_IDLE_BIT];
		end
		// low wake level ends power-down, counting waits for high
		if (pd_reg && !WAKE_INT_N) begin
			pd_next = 1'b0;
			hold_next = 1'b1;
		end else if (hold_reg && WAKE_INT_N) begin
			hold_next = 1'b0;
		end
	end

	// ------------------------------------------------
	// watchdog state and reset pulse
	// ------------------------------------------------
	always_comb begin
		st_next = st_reg;
		pcnt_next = pcnt_reg;
		rst_out_next = rst_out_reg;
		unique case (st_reg)
			wdtr_pkg::WD_OFF: begin
				// inactive until the key pair arrives
				if (key_done) begin
					st_next = wdtr_pkg::WD_ON;
				end
			end
			wdtr_pkg::WD_ON: begin
				// no software path back to off
				if (lnk.ovf) begin
					st_next = wdtr_pkg::WD_FIRE;
					rst_out_next = 1'b1;
					pcnt_next = '0;
				end
			end
			wdtr_pkg::WD_FIRE: begin
				if (pcnt_reg == wdtr_pkg::PULSE_LAST) begin
					st_next = wdtr_pkg::WD_OFF;
					rst_out_next = 1'b0;
				end else begin
					pcnt_next = pcnt_reg + wdtr_pkg::PW'(1);
				end
			end
		endcase
	end

	// register stage for all state but ready_reg and resp_reg
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			dp_reg <= 1'b0;
			dp_wr_reg <= 1'b0;
			dp_addr_reg <= '0;
			rdata_reg <= '0;
			seq_reg <= 1'b0;
			period_reg <= wdtr_pkg::SEL_RST;
			act_sel_reg <= wdtr_pkg::SEL_RST;
			pd_reg <= 1'b0;
			idle_reg <= 1'b0;
			hold_reg <= 1'b0;
			clr_reg <= 1'b0;
			st_reg <= wdtr_pkg::WD_OFF;
			pcnt_reg <= '0;
			rst_out_reg <= 1'b0;
		end else begin
			dp_reg <= dp_next;
			dp_wr_reg <= dp_wr_next;
			dp_addr_reg <= dp_addr_next;
			rdata_reg <= rdata_next;
			seq_reg <= seq_next;
			period_reg <= period_next;
			act_sel_reg <= act_sel_next;
			pd_reg <= pd_next;
			idle_reg <= idle_next;
			hold_reg <= hold_next;
			clr_reg <= clr_next;
			st_reg <= st_next;
			pcnt_reg <= pcnt_next;
			rst_out_reg <= rst_out_next;
		end
	end

	// ------------------------------------------------
	// counter chain
	// ------------------------------------------------
	// halted oscillator or pending wake hold stops the chain
	assign lnk.run = (st_reg == wdtr_pkg::WD_ON) && !pd_reg && !hold_reg;
	assign lnk.clear = clr_reg;
	assign lnk.sel = act_sel_reg;

	wdtr_counter u_counter (
		.CORE_CLK(CORE_CLK),
		.NRST(NRST),
		.lnk(lnk)
	);

	// zero wait states, always okay; hreadyout/hresp are fixed flops
	logic ready_reg; // slave ready, never stalls
	logic resp_reg; // response code, always okay
	// both outputs come straight from flops, even though they never change
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			ready_reg <= 1'b1;
			resp_reg <= 1'b0;
		end else begin
			ready_reg <= 1'b1;
			resp_reg <= 1'b0;
		end
	end
	assign HREADYOUT = ready_reg;
	assign HRESP = resp_reg;
	assign HRDATA = rdata_reg;
	assign CHIP_RST_OUT = rst_out_reg;

	// ------------------------------------------------
	// checks
	// ------------------------------------------------
	arm_on_key_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(key_done && st_reg == wdtr_pkg::WD_OFF) |=> (st_reg == wdtr_pkg::WD_ON))
		else $error("key pair did not arm");
	no_stop_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(st_reg == wdtr_pkg::WD_ON && !lnk.ovf) |=> (st_reg == wdtr_pkg::WD_ON))
		else $error("armed watchdog left on without overflow");
	pulse_length_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		$rose(rst_out_reg) |-> ##95 rst_out_reg ##1 !rst_out_reg)
		else $error("reset pulse not 96 periods");
	ovf_fires_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(st_reg == wdtr_pkg::WD_ON && lnk.ovf) |=> rst_out_reg)
		else $error("overflow gave no reset pulse");
	sel_locked_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(st_reg != wdtr_pkg::WD_OFF) |=> $stable(act_sel_reg) && $stable(period_reg))
		else $error("period changed while armed");
	pd_frozen_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		pd_reg |-> !lnk.run ##1 !rst_out_reg || $past(rst_out_reg))
		else $error("power-down did not freeze");
	hold_until_high_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(pd_reg && !WAKE_INT_N) |=> hold_reg && !lnk.run)
		else $error("counting resumed while wake pin low");
	off_no_count_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(st_reg == wdtr_pkg::WD_OFF) |-> !lnk.run && !rst_out_reg)
		else $error("disarmed watchdog counting");
endmodule : wdtr_top

// >>> sim/watchdog_timeout_reset_tb.sv
/*
 * self-checking bench of the watchdog restart unit: register reads, unlock
 * sequences, power modes, restarts and the overflow reset pulse.
 * assumes wdtr_pkg, wdtr_cnt_if, wdtr_counter and wdtr_top are compiled first.
 */
`timescale 1ns/1ps
module watchdog_timeout_reset_tb;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic CORE_CLK, NRST, HSEL, HWRITE, HREADY, HRESP, HREADYOUT;
	logic WAKE_INT_N, CHIP_RST_OUT;
	logic [31:0] HADDR, HWDATA, HRDATA;
	logic [1:0] HTRANS;
	logic [2:0] HSIZE;
	logic [63:0] exp_q[$]; // pending read notes, {expected, mask}
	logic [63:0] note; // note taken off by the monitor
	logic rd_pend; // a read sits in its data phase
	logic [31:0] seed, v, c1; // random state, last read data, earlier count
	int bad_count, n_checks, t;

	assign HREADY = HREADYOUT; // one slave, so its ready is the bus ready

	wdtr_top dut (.CORE_CLK, .NRST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
		.HREADY, .HRDATA, .HREADYOUT, .HRESP, .WAKE_INT_N, .CHIP_RST_OUT);

	initial begin
		CORE_CLK = 1'b0;
		forever #5 CORE_CLK = ~CORE_CLK;
	end

	// ----------------------------------------
	// compare, report and random helpers
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_checks++;
		if (seen !== want) begin
			bad_count++;
			$display("Error at %0t ns: saw %h, wanted %h", $time, seen, want);
		end
	endtask : check

	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// ----------------------------------------
	// ahb-lite master, single word transfers
	// ----------------------------------------
	// bounded wait for ready; a hung slave ends the run as a mismatch
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge CORE_CLK);
			n++;
		end while (HREADYOUT !== 1'b1 && n < 64);
		if (HREADYOUT !== 1'b1) begin
			bad_count++;
			$display("Error at %0t ns: no ready from slave", $time);
			stop_test();
		end
	endtask : wait_ready

	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] want, input logic [31:0] mk);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HWRITE <= wr;
		HADDR <= {20'h0, a};
		if (!wr) exp_q.push_back({want, mk}); // mask zero: value only returned
		wait_ready();
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		wait_ready();
		v = HRDATA;
	endtask : bus

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h0, d}, 32'h0, 32'h0);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] want, input logic [31:0] mk);
		bus(1'b0, a, 32'h0, want, mk);
	endtask : rd

	// unlock pair, back to back; also the restart sequence once armed
	task automatic arm();
		wr(wdtr_pkg::A_RESTART, wdtr_pkg::KEY_FIRST);
		wr(wdtr_pkg::A_RESTART, wdtr_pkg::KEY_SECOND);
	endtask : arm

	task automatic idle(input int n);
		repeat (n) @(posedge CORE_CLK);
	endtask : idle

	// ----------------------------------------
	// read monitor: oldest note against data phase
	// ----------------------------------------
	always @(posedge CORE_CLK) begin
		if (rd_pend && HREADYOUT === 1'b1) begin
			note = exp_q.pop_front();
			if (note[31:0] != 32'h0) check(HRDATA & note[31:0], note[63:32] & note[31:0]);
			check({31'h0, HRESP}, 32'h0);
		end
		if (HREADYOUT === 1'b1) rd_pend = NRST && HSEL && HTRANS[1] && !HWRITE;
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		NRST = 1'b0;
		HSEL = 1'b0;
		HADDR = 32'h0;
		HTRANS = 2'h0;
		HWRITE = 1'b0;
		HSIZE = 3'h2;
		HWDATA = 32'h0;
		WAKE_INT_N = 1'b1;
		rd_pend = 1'b0;
		seed = 32'hA177;
		bad_count = 0;
		n_checks = 0;
		idle(4);
		NRST <= 1'b1;
		idle(1);
		// reset state and an unmapped word
		check({31'h0, CHIP_RST_OUT}, 32'h0);
		check({30'h0, HREADYOUT, HRESP}, 32'h2);
		rd(wdtr_pkg::A_STATUS, 32'h0, 32'h7);
		rd(wdtr_pkg::A_PERIOD, 32'h0, 32'h7);
		rd(wdtr_pkg::A_RESTART, 32'h0, 32'hFFFFFFFF);
		rd(12'hFF0, 32'h0, 32'hFFFFFFFF);
		// select field takes random values while off
		repeat (4) begin
			seed = lfsr(seed);
			wr(wdtr_pkg::A_PERIOD, seed[7:0]);
			rd(wdtr_pkg::A_PERIOD, {29'h0, seed[2:0]}, 32'h7);
		end
		wr(wdtr_pkg::A_PERIOD, 8'h00);
		// broken pairs: a read between, then a wrong byte between
		wr(wdtr_pkg::A_RESTART, wdtr_pkg::KEY_FIRST);
		rd(wdtr_pkg::A_STATUS, 32'h0, 32'h1);
		wr(wdtr_pkg::A_RESTART, wdtr_pkg::KEY_SECOND);
		rd(wdtr_pkg::A_STATUS, 32'h0, 32'h1);
		wr(wdtr_pkg::A_RESTART, wdtr_pkg::KEY_FIRST);
		wr(wdtr_pkg::A_RESTART, 8'h40 | (seed[7:0] & 8'hFE)); // never either key
		wr(wdtr_pkg::A_RESTART, wdtr_pkg::KEY_SECOND);
		rd(wdtr_pkg::A_STATUS, 32'h0, 32'h1);
		// arm, then try to reprogram and to stop it
		arm();
		rd(wdtr_pkg::A_STATUS, 32'h1, 32'h3);
		wr(wdtr_pkg::A_PERIOD, 8'h07);
		rd(wdtr_pkg::A_PERIOD, 32'h0, 32'h7);
		wr(wdtr_pkg::A_STATUS, 8'h00);
		wr(wdtr_pkg::A_MODE, 8'h00);
		rd(wdtr_pkg::A_STATUS, 32'h1, 32'h1);
		// one step per 12 clocks, in run mode and in idle
		for (int m = 0; m < 2; m++) begin
			wr(wdtr_pkg::A_MODE, {6'h0, m[0], 1'b0});
			rd(wdtr_pkg::A_COUNT, 32'h0, 32'h0);
			c1 = v;
			idle(240);
			rd(wdtr_pkg::A_COUNT, 32'h0, 32'h0);
			v = v - c1;
			check({31'h0, v >= 32'd19 && v <= 32'd21}, 32'h1);
		end
		// restart clears the chain; done just before power-down
		wr(wdtr_pkg::A_MODE, 8'h00);
		arm();
		idle(2);
		rd(wdtr_pkg::A_COUNT, 32'h0, 32'h0);
		check({31'h0, v < 32'h2}, 32'h1);
		// power-down stops the chain at zero; wake pin low holds it off
		wr(wdtr_pkg::A_MODE, 8'h01);
		idle(600);
		rd(wdtr_pkg::A_COUNT, 32'h0, 32'hFFFFFFFF);
		rd(wdtr_pkg::A_STATUS, 32'h1, 32'h7);
		WAKE_INT_N <= 1'b0;
		idle(100);
		rd(wdtr_pkg::A_STATUS, 32'h5, 32'h7);
		rd(wdtr_pkg::A_COUNT, 32'h0, 32'hFFFFFFFF);
		WAKE_INT_N <= 1'b1;
		idle(3);
		rd(wdtr_pkg::A_STATUS, 32'h1, 32'h7);
		idle(240);
		rd(wdtr_pkg::A_COUNT, 32'h0, 32'h0);
		check({31'h0, v >= 32'd18}, 32'h1);
		// hardware reset out of power-down leaves it off
		wr(wdtr_pkg::A_MODE, 8'h01);
		NRST <= 1'b0;
		idle(4);
		NRST <= 1'b1;
		idle(1);
		rd(wdtr_pkg::A_STATUS, 32'h0, 32'h7);
		idle(300);
		rd(wdtr_pkg::A_COUNT, 32'h0, 32'hFFFFFFFF);
		// overflow at select 0, no restart given on purpose
		arm();
		t = 0;
		while (CHIP_RST_OUT !== 1'b1 && t < 197000) begin
			@(negedge CORE_CLK);
			t++;
		end
		check({31'h0, t >= 196590 && t <= 196630}, 32'h1);
		t = 0;
		while (CHIP_RST_OUT === 1'b1 && t < 200) begin
			@(negedge CORE_CLK);
			t++;
		end
		check(32'(t), 32'd96);
		@(posedge CORE_CLK);
		rd(wdtr_pkg::A_STATUS, 32'h0, 32'h7);
		idle(2);
		stop_test();
	end
endmodule : watchdog_timeout_reset_tb
